// >>> hdl/asd_regs.svh
// Register selects, field positions, reset values and counts of the
// converter status and mode block.
// Assumes inclusion from the design module asd_ctrl by bare name.
`ifndef ASD_REGS_SVH
`define ASD_REGS_SVH

// -----------------------------------------------------------------
// Register selects
// -----------------------------------------------------------------
`define ASD_RS_STATUS      2'h0
`define ASD_RS_MODE        2'h1
`define ASD_RS_FILTER      2'h2
`define ASD_RS_DATA        2'h3

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define ASD_MODE_RESET     8'h02
`define ASD_FILTER_RESET   8'h07
`define ASD_DATA_RESET     16'h0000
`define ASD_CHANNEL_RESET  2'h0

// -----------------------------------------------------------------
// Status fields: bits 5..3 are fixed at 0, 0, 1
// -----------------------------------------------------------------
`define ASD_STATUS_FIXED   3'h1

// -----------------------------------------------------------------
// Operating mode encodings
// -----------------------------------------------------------------
`define ASD_MD_CONTINUOUS  2'h0
`define ASD_MD_SINGLE      2'h2
`define ASD_MD_STANDBY     2'h3

// -----------------------------------------------------------------
// Serial counts
// -----------------------------------------------------------------
`define ASD_CMD_LAST       5'h06
`define ASD_SHORT_LEN      5'h08
`define ASD_LONG_LEN       5'h10
`define ASD_ONES_LAST      6'h1F

`endif

// >>> hdl/asd_pkg.sv
// Types shared by the converter status and mode block.
// Assumes the constants header sits beside it.
package asd_pkg;

  typedef enum logic [1:0] {ASD_HUNT, ASD_CMD, ASD_RX, ASD_TX} asd_state_t;

  typedef struct packed {
    logic [1:0] operatingModeBits;
    logic [1:0] inputRangeBits;
    logic       burnoutCurrentEnable;
    logic       zeroHi;
    logic       bufferEnable;
    logic       zeroLo;
  } asd_mode_t;

  typedef struct packed {
    logic        done;
    logic        clamped;
    logic        preUpdate;
    logic [15:0] result;
  } asd_conv_t;

  typedef struct packed {
    logic       mustBeZero;
    logic [1:0] registerSelectBits;
    logic       readDir;
    logic       contRead;
    logic [1:0] channelSelectBits;
  } asd_cmd_t;

endpackage

// >>> hdl/asd_pin_sync.sv
// Two-flop synchroniser for the serial clock and data pins, with
// edge detection on the serial clock.
// Assumes pins are asynchronous to core_clk and at least 3 cycles wide.
`timescale 1ns/10ps
module asd_pin_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic sclk,
  input  wire logic din,
  output logic      dinSync,
  output logic      sclkRise,
  output logic      sclkFall
);

  logic [1:0] meta;
  logic [1:0] stable;
  logic       sclkLast;

  // -----------------------------------------------------------------
  // Synchroniser stages
  // -----------------------------------------------------------------
  // Idle high serial clock, so stages reset high for it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta   <= 2'h2;
      stable <= 2'h2;
    end else begin
      meta   <= {sclk, din};
      stable <= meta;
    end
  end

  // -----------------------------------------------------------------
  // Edge detection
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclkLast <= 1'b1;
      sclkRise <= 1'b0;
      sclkFall <= 1'b0;
      dinSync  <= 1'b0;
    end else begin
      sclkLast <= stable[1];
      sclkRise <= stable[1] & ~sclkLast;
      sclkFall <= ~stable[1] & sclkLast;
      dinSync  <= stable[0];
    end
  end

endmodule

// >>> hdl/asd_status_flags.sv
// Not-ready and error flags of the status register.
// Assumes event pulses are one core_clk cycle wide, same clock domain.
`timescale 1ns/10ps
module asd_status_flags (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic convDone,
  input  wire logic convClamped,
  input  wire logic preUpdate,
  input  wire logic dataRead,
  input  wire logic modeWrite,
  input  wire logic powerDownEnter,
  input  wire logic startWrite,
  output logic      notReady,
  output logic      convError
);

  // -----------------------------------------------------------------
  // Not-ready flag
  // -----------------------------------------------------------------
  // Restart and warning events win over a new result; a new result wins
  // over a read in the same cycle so fresh data is never hidden.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      notReady <= 1'b1;
    end else if (modeWrite || powerDownEnter || preUpdate) begin
      notReady <= 1'b1;
    end else if (convDone) begin
      notReady <= 1'b0;
    end else if (dataRead) begin
      notReady <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Error flag
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      convError <= 1'b0;
    end else if (convDone && !modeWrite) begin
      convError <= convClamped;
    end else if (startWrite) begin
      convError <= 1'b0;
    end
  end

endmodule

// >>> hdl/asd_ctrl.sv
// Serial port, status and mode registers of the sigma-delta converter.
// Assumes a host on sclk/din/dout (clock idles high, data taken on the
// rising edge) and a converter core on core_clk giving result pulses.
`timescale 1ns/10ps
`include "asd_regs.svh"

module asd_ctrl
  import asd_pkg::*;
#(
  parameter logic VARIANT_ID_BIT = 1'b1  // Arbitrary value
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       din,
  input  wire asd_conv_t  conv,
  output logic            doutRdy,
  output asd_mode_t       modeCfg,
  output logic [1:0]      channelSelectBits,
  output logic [7:0]      filterCfg,
  output logic            powerDown,
  output logic            filterRestart
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic        dinSync;
  logic        sclkRise;
  logic        sclkFall;
  asd_state_t  state;
  logic [4:0]  bitCnt;
  logic [4:0]  xferLen;
  logic [6:0]  cmdShift;
  logic [15:0] rxShift;
  logic [15:0] txShift;
  logic [1:0]  regSel;
  logic [5:0]  onesCnt;
  logic        ifReset;
  logic [15:0] dataReg;
  logic        notReady;
  logic        convError;
  logic        dataRead;
  logic        modeWrite;
  logic        startWrite;
  logic        powerDownEnter;
  logic        singleBusy;
  asd_cmd_t    cmdNow;
  logic        cmdDone;
  logic        xferLast;
  logic        rxDone;
  asd_mode_t   rxMode;

  // -----------------------------------------------------------------
  // Functions
  // -----------------------------------------------------------------
  function automatic logic [4:0] lengthOf(input logic [1:0] sel);
    lengthOf = (sel == `ASD_RS_DATA) ? `ASD_LONG_LEN : `ASD_SHORT_LEN;
  endfunction

  function automatic logic [7:0] statusByte(input logic       nr,
                                            input logic       err,
                                            input logic [1:0] ch);
    statusByte = {nr, err, `ASD_STATUS_FIXED, VARIANT_ID_BIT, ch};
  endfunction

  // Mode values with the must-be-zero positions forced low
  function automatic asd_mode_t cleanMode(input asd_mode_t m);
    cleanMode        = m;
    cleanMode.zeroHi = 1'b0;
    cleanMode.zeroLo = 1'b0;
  endfunction

  function automatic logic startsConv(input logic [1:0] md);
    startsConv = (md == `ASD_MD_CONTINUOUS) || (md == `ASD_MD_SINGLE);
  endfunction

  // -----------------------------------------------------------------
  // Pin synchroniser and status flags
  // -----------------------------------------------------------------
  asd_pin_sync pinSync (
    .core_clk (core_clk),
    .rst      (rst),
    .sclk     (sclk),
    .din      (din),
    .dinSync  (dinSync),
    .sclkRise (sclkRise),
    .sclkFall (sclkFall)
  );

  asd_status_flags flags (
    .core_clk       (core_clk),
    .rst            (rst),
    .convDone       (conv.done),
    .convClamped    (conv.clamped),
    .preUpdate      (conv.preUpdate),
    .dataRead       (dataRead),
    .modeWrite      (modeWrite),
    .powerDownEnter (powerDownEnter),
    .startWrite     (startWrite),
    .notReady       (notReady),
    .convError      (convError)
  );

  // -----------------------------------------------------------------
  // Decode of the command byte and transfer ends
  // -----------------------------------------------------------------
  assign cmdNow   = asd_cmd_t'({cmdShift[5:0], dinSync});
  assign cmdDone  = sclkRise && (state == ASD_CMD) && (bitCnt == `ASD_CMD_LAST);
  assign xferLast = (bitCnt == (xferLen - 5'h01));
  assign rxDone   = sclkRise && (state == ASD_RX) && xferLast;
  assign rxMode   = asd_mode_t'({rxShift[6:0], dinSync});

  // -----------------------------------------------------------------
  // Host reset by a run of ones
  // -----------------------------------------------------------------
  // Thirty-two ones in a row return the port and the mode, filter and channel
  // registers to reset, which lets a host recover from a lost bit count.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      onesCnt <= 6'h00;
      ifReset <= 1'b0;
    end else begin
      ifReset <= sclkRise && dinSync && (onesCnt == `ASD_ONES_LAST);
      if (sclkRise) begin
        onesCnt <= dinSync ? onesCnt + 6'h01 : 6'h00;
      end
    end
  end

  // -----------------------------------------------------------------
  // Serial state machine
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= ASD_HUNT;
      bitCnt   <= 5'h00;
      cmdShift <= 7'h00;
      regSel   <= `ASD_RS_STATUS;
      xferLen  <= `ASD_SHORT_LEN;
    end else if (ifReset) begin
      state  <= ASD_HUNT;
      bitCnt <= 5'h00;
    end else if (sclkRise) begin
      unique case (state)
        ASD_HUNT: begin
          bitCnt <= 5'h00;
          if (!dinSync) begin
            state <= ASD_CMD;
          end
        end
        ASD_CMD: begin
          cmdShift <= {cmdShift[5:0], dinSync};
          bitCnt   <= bitCnt + 5'h01;
          if (bitCnt == `ASD_CMD_LAST) begin
            bitCnt  <= 5'h00;
            regSel  <= cmdNow.registerSelectBits;
            xferLen <= lengthOf(cmdNow.registerSelectBits);
            if (cmdNow.readDir) begin
              state <= ASD_TX;
            // select zero on write is the command byte itself
            end else if (cmdNow.registerSelectBits == `ASD_RS_STATUS) begin
              state <= ASD_HUNT;
            end else begin
              state <= ASD_RX;
            end
          end
        end
        ASD_RX, ASD_TX: begin
          bitCnt <= bitCnt + 5'h01;
          if (xferLast) begin
            state  <= ASD_HUNT;
            bitCnt <= 5'h00;
          end
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Receive shifter
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxShift <= 16'h0000;
    end else if (sclkRise && (state == ASD_RX)) begin
      rxShift <= {rxShift[14:0], dinSync};
    end
  end

  // -----------------------------------------------------------------
  // Transmit shifter
  // -----------------------------------------------------------------
  // Loaded as the command completes so the first falling edge can
  // present the top bit; short registers sit left justified.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txShift <= 16'h0000;
    end else if (cmdDone) begin
      unique case (cmdNow.registerSelectBits)
        `ASD_RS_STATUS: txShift <= {statusByte(notReady, convError, channelSelectBits), 8'h00};
        `ASD_RS_MODE:   txShift <= {modeCfg, 8'h00};
        `ASD_RS_FILTER: txShift <= {filterCfg, 8'h00};
        `ASD_RS_DATA:   txShift <= dataReg;
      endcase
    end else if (sclkFall && (state == ASD_TX)) begin
      txShift <= {txShift[14:0], 1'b0};
    end
  end

  // -----------------------------------------------------------------
  // Data out and ready pin
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      doutRdy <= 1'b1;
    end else if (state == ASD_TX) begin
      if (sclkFall) begin
        doutRdy <= txShift[15];
      end
    end else begin
      doutRdy <= notReady;
    end
  end

  // -----------------------------------------------------------------
  // Data register and read event
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dataReg  <= `ASD_DATA_RESET;
      dataRead <= 1'b0;
    end else begin
      // only a finished data read counts
      dataRead <= sclkRise && (state == ASD_TX) && xferLast && (regSel == `ASD_RS_DATA);
      if (conv.done) begin
        dataReg <= conv.result;
      end
    end
  end

  // -----------------------------------------------------------------
  // Mode and filter registers
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modeCfg   <= asd_mode_t'(`ASD_MODE_RESET);
      filterCfg <= `ASD_FILTER_RESET;
    end else if (ifReset) begin
      modeCfg   <= asd_mode_t'(`ASD_MODE_RESET);
      filterCfg <= `ASD_FILTER_RESET;
    end else if (rxDone) begin
      if (regSel == `ASD_RS_MODE) begin
        modeCfg <= cleanMode(rxMode);
      end else if (regSel == `ASD_RS_FILTER) begin
        filterCfg <= {rxShift[6:0], dinSync};
      end
    end
  end

  // -----------------------------------------------------------------
  // Channel select
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      channelSelectBits <= `ASD_CHANNEL_RESET;
    end else if (ifReset) begin
      channelSelectBits <= `ASD_CHANNEL_RESET;
    end else if (cmdDone) begin
      channelSelectBits <= cmdNow.channelSelectBits;
    end
  end

  // -----------------------------------------------------------------
  // Mode write events
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modeWrite      <= 1'b0;
      startWrite     <= 1'b0;
      powerDownEnter <= 1'b0;
    end else begin
      modeWrite      <= (rxDone && (regSel == `ASD_RS_MODE)) || ifReset;
      startWrite     <= rxDone && (regSel == `ASD_RS_MODE) &&
                        startsConv(rxMode.operatingModeBits);
      powerDownEnter <= rxDone && (regSel == `ASD_RS_MODE) &&
                        (rxMode.operatingModeBits == `ASD_MD_STANDBY);
    end
  end

  // -----------------------------------------------------------------
  // Modulator and filter restart
  // -----------------------------------------------------------------
  // A channel change also restarts, since the old result no longer
  // belongs to the selected input.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      filterRestart <= 1'b0;
    end else begin
      filterRestart <= (rxDone && (regSel == `ASD_RS_MODE)) || ifReset ||
                       (cmdDone && (cmdNow.channelSelectBits != channelSelectBits));
    end
  end

  // -----------------------------------------------------------------
  // Operating mode and power-down
  // -----------------------------------------------------------------
  // Single mode powers up for one result and drops back afterwards.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      singleBusy <= 1'b0;
    end else if (modeWrite) begin
      singleBusy <= (modeCfg.operatingModeBits == `ASD_MD_SINGLE);
    end else if (conv.done) begin
      singleBusy <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      powerDown <= 1'b0;
    end else begin
      unique case (modeCfg.operatingModeBits)
        `ASD_MD_STANDBY: powerDown <= 1'b1;
        `ASD_MD_SINGLE:  powerDown <= ~singleBusy && ~modeWrite;
        default:         powerDown <= 1'b0;
      endcase
    end
  end

endmodule

// >>> sim/asd_ctrl_properties.sv
// Concurrent checks on the ports of the converter status and mode block.
// Assumes it is bound to asd_ctrl and that the bench leaves sclk idle
// for at least 20 core_clk cycles before pulsing the converter events.
`timescale 1ns/10ps
module asd_ctrl_checker
  import asd_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire logic      sclk,
  input  wire asd_conv_t conv,
  input  wire logic      doutRdy,
  input  wire asd_mode_t modeCfg,
  input  wire logic      powerDown,
  input  wire logic      filterRestart
);
  // -----------------------------------------------------------------
  // Link activity
  // -----------------------------------------------------------------
  logic [5:0] idleCnt;

  // Cycles since sclk was last low; the pin lags through a synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idleCnt <= 6'h00;
    end else if (!sclk) begin
      idleCnt <= 6'h00;
    end else if (idleCnt != 6'h3F) begin
      idleCnt <= idleCnt + 6'h01;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // -----------------------------------------------------------------
  // Properties
  // -----------------------------------------------------------------
  AST_MODE_ZERO_BITS: assert property (
    !modeCfg.zeroHi && !modeCfg.zeroLo) else $error("mode bit 2 or 0 set");
  AST_DONE_READY: assert property (
    conv.done && !conv.preUpdate && idleCnt >= 6'h14 |-> ##2 !doutRdy)
    else $error("ready pin not low after result");
  AST_PRE_NOT_READY: assert property (
    conv.preUpdate && idleCnt >= 6'h14 |-> ##2 doutRdy)
    else $error("ready pin not high after warning");
  AST_MODE_RESTART: assert property (
    $changed(modeCfg) |-> ##[0:2] filterRestart) else $error("no restart on mode write");
  AST_MODE_READY: assert property (
    $changed(modeCfg) |-> ##[1:5] doutRdy) else $error("not ready not set by mode write");
  AST_STANDBY_DOWN: assert property (
    $stable(modeCfg) && modeCfg.operatingModeBits == 2'h3 |-> powerDown)
    else $error("standby without power down");
  AST_CONT_AWAKE: assert property (
    $stable(modeCfg) && modeCfg.operatingModeBits == 2'h0 |-> !powerDown)
    else $error("power down in continuous mode");
  AST_MODE_VIA_PORT: assert property (
    $changed(modeCfg) |-> idleCnt < 6'h0C) else $error("mode changed without transfer");
endmodule

bind asd_ctrl asd_ctrl_checker chk (
  .core_clk      (core_clk),
  .rst           (rst),
  .sclk          (sclk),
  .conv          (conv),
  .doutRdy       (doutRdy),
  .modeCfg       (modeCfg),
  .powerDown     (powerDown),
  .filterRestart (filterRestart)
);

// >>> sim/asd_host_model.sv
// Host side of the three-wire serial port.
// Assumes sclk idles high and the device takes din on the rising edge.
`timescale 1ns/10ps
module asd_host_model (
  output logic      sclk,
  output logic      din,
  input  wire logic doutRdy
);
  initial begin
    sclk = 1'b1;
    din  = 1'b1;
  end

  // -----------------------------------------------------------------
  // Transfer
  // -----------------------------------------------------------------
  // MSB first, clock stands high between frames
  task automatic xfer(input logic [31:0] bits, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din  = bits[i];
      #16;
      sclk = 1'b1;
      // Sample early in the high phase, before the last bit is withdrawn
      #4;
      rx = {rx[14:0], doutRdy};
      #12;
    end
  endtask
endmodule

// >>> sim/tb_asd_ctrl.sv
// Self-checking bench of the converter status and mode block.
// Assumes the host model drives the serial pins and the checker is bound.
`timescale 1ns/10ps
module tb_asd_ctrl;
  import asd_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst;
  logic        sclk;
  logic        din;
  logic        doutRdy;
  logic        powerDown;
  asd_conv_t   conv;
  asd_mode_t   modeCfg;
  logic [1:0]  channelSelectBits;
  logic [7:0]  filterCfg;
  logic [15:0] rx;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;

  asd_ctrl dut (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .din(din), .conv(conv),
    .doutRdy(doutRdy), .modeCfg(modeCfg), .channelSelectBits(channelSelectBits),
    .filterCfg(filterCfg),
    .powerDown(powerDown), .filterRestart()
  );
  asd_host_model host (.sclk(sclk), .din(din), .doutRdy(doutRdy));

  always #2 core_clk = ~core_clk;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      summarize;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle gap keeps the converter events clear of the link synchroniser
  task automatic xf(input logic [31:0] b, input int n);
    host.xfer(b, n, rx);
    repeat (25) @(posedge core_clk);
  endtask

  task automatic st(input logic [7:0] cmd, input logic [7:0] exp);
    xf({16'h0000, cmd, 8'h00}, 16);
    check(rx[7:0], exp);
  endtask

  task automatic pulse(input logic d, input logic c, input logic p);
    @(posedge core_clk);
    conv <= {d, c, p, 16'hC35A};
    @(posedge core_clk);
    conv <= {3'h0, 16'hC35A};
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset;
    check(modeCfg, 8'h02);
    check(doutRdy, 1'b1);
    check(filterCfg, 8'h07);
    check(channelSelectBits, 2'h0);
    xf({12'h000, 4'hF, 8'h08, 8'h00}, 20);
    check(rx[7:0], 8'h8C);
    xf({24'h000000, 8'h00}, 8);
    st(8'h08, 8'h8C);
    st(8'h28, 8'h07);
    $display("reset test done");
  endtask

  task automatic t_convert;
    pulse(1'b1, 1'b1, 1'b0);
    check(doutRdy, 1'b0);
    st(8'h08, 8'h4C);
    st(8'h08, 8'h4C);
    pulse(1'b0, 1'b0, 1'b1);
    check(doutRdy, 1'b1);
    st(8'h08, 8'hCC);
    pulse(1'b1, 1'b0, 1'b0);
    st(8'h08, 8'h0C);
    xf({8'h00, 8'h30, 16'h1234}, 24);
    xf({8'h00, 8'h38, 16'h0000}, 24);
    check(rx, 16'hC35A);
    st(8'h08, 8'h8C);
    $display("conversion test done");
  endtask

  task automatic t_mode;
    pulse(1'b1, 1'b1, 1'b0);
    xf({16'h0000, 8'h12, 8'h3A}, 16);
    check(modeCfg, 8'h3A);
    st(8'h0A, 8'h8E);
    xf({16'h0000, 8'h1A, 8'h00}, 16);
    check(rx[7:0], 8'h3A);
    xf({16'h0000, 8'h20, 8'h45}, 16);
    check(filterCfg, 8'h45);
    st(8'h28, 8'h45);
    xf({16'h0000, 8'h12, 8'hFF}, 16);
    check(modeCfg, 8'hFA);
    check(powerDown, 1'b1);
    // A run of ones returns port, mode, filter and channel to reset
    xf(32'hFFFFFFFF, 32);
    check(modeCfg, 8'h02);
    check(filterCfg, 8'h07);
    check(channelSelectBits, 2'h0);
    check(powerDown, 1'b0);
    xf({16'h0000, 8'h12, 8'h82}, 16);
    check(modeCfg, 8'h82);
    xf({16'h0000, 8'h12, 8'h02}, 16);
    check(powerDown, 1'b0);
    xf({24'h000000, 8'h03}, 8);
    check(channelSelectBits, 2'h3);
    st(8'h0B, 8'h8F);
    $display("mode test done");
  endtask

  initial begin
    rst  = 1'b1;
    conv = '0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_reset;
    t_convert;
    t_mode;
    summarize;
  end
endmodule
